// ---- shared/ultc_pkg.sv ----
// What this block does
// - 32-bit test register at 0C4h; reserved bits read-only; fields reset zero except the current trim.
// - bit 22 low enables the full/low-speed driver, high tri-states it.
// - bits 21 and 20 drive the positive and negative lines when enabled.
// - bit 19 reads back the full/low-speed differential receiver output.
// - bits 15:14 mark valid transmit bits; 10 must never be written.
// - the two high-speed transmit bits go to the line lsb first.
// - bit 11 powers the current source; forced on in high-speed mode.
// - bits 10:8 select the high-speed output current step.
// - the current trim is reloaded from its image across usb and lite resets, so a software-written value is not kept.
// - bits 7 to 4 each switch one pull-up or pull-down termination.
// - bit 1 selects high-speed driver low-power or active transmit mode.
// - at power-up trim loads from eeprom, else otp, else 000b.
// - usb or lite reset restores trim to eeprom image, else 000b.
package ultc_pkg;
   // =====================================================================
   // register map
   localparam logic [11:0] ULTC_TEST_OFFS = 12'h0C4;
   localparam logic [31:0] ULTC_WRITE_MASK = 32'h0070F8F2;
   localparam int ULTC_FS_OE_N_BIT = 22;
   localparam int ULTC_FS_POS_BIT = 21;
   localparam int ULTC_FS_NEG_BIT = 20;
   localparam int ULTC_FS_RX_BIT = 19;
   localparam int ULTC_TXVALID_LSB = 14;
   localparam int ULTC_TXDATA_LSB = 12;
   localparam int ULTC_CS_EN_BIT = 11;
   localparam int ULTC_TRIM_LSB = 8;
   localparam int ULTC_TERM_LSB = 4;
   localparam int ULTC_TXACTIVE_BIT = 1;
   // =====================================================================
   // reset values
   localparam logic [31:0] ULTC_RESET_VAL = 32'h00000000;
   localparam logic [2:0] ULTC_TRIM_DEFAULT = 3'h0;
   localparam logic [1:0] ULTC_VALID_ILLEGAL = 2'h2;
   localparam logic [31:0] ULTC_UNMAPPED_DATA = 32'h00000000;
   typedef enum logic [1:0] {
      ULTC_IDLE = 2'b00,
      ULTC_ACK = 2'b01
   } ultc_bus_state_t;
endpackage : ultc_pkg

// ---- hdl/ultc_trim_keeper.sv ----
`timescale 1ns/1ps
module ultc_trim_keeper
   import ultc_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // configuration sources
   input wire logic eeprom_present_i,
   input wire logic [2:0] cfg_output_current_trim_i,
   input wire logic otp_programmed_i,
   input wire logic [2:0] otp_trim_i,
   input wire logic usb_reset_i,
   input wire logic lite_reset_i,
   // software write
   input wire logic sw_we_i,
   input wire logic [2:0] sw_trim_i,
   // current value
   output logic [2:0] trim_o
);
   logic [2:0] trim_reg, trim_next;
   logic [2:0] image_reg, image_next;
   logic loaded_reg, loaded_next;

   always_comb begin
      trim_next = trim_reg;
      image_next = image_reg;
      loaded_next = 1'b1;
      if (!loaded_reg) begin
         // power-up load, caught after reset release
         if (eeprom_present_i) begin
            trim_next = cfg_output_current_trim_i;
         end else if (otp_programmed_i) begin
            trim_next = otp_trim_i;
         end else begin
            trim_next = ULTC_TRIM_DEFAULT;
         end
         image_next = eeprom_present_i ? cfg_output_current_trim_i
                                       : ULTC_TRIM_DEFAULT;
      end else if (usb_reset_i || lite_reset_i) begin
         trim_next = image_reg;
      end else if (sw_we_i) begin
         trim_next = sw_trim_i;
      end
   end

   // rstn_i is the power-up reset only; usb and lite resets never clear
   // this flop, which is what protects the trim image
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         trim_reg <= ULTC_TRIM_DEFAULT;
         image_reg <= ULTC_TRIM_DEFAULT;
         loaded_reg <= 1'b0;
      end else begin
         trim_reg <= trim_next;
         image_reg <= image_next;
         loaded_reg <= loaded_next;
      end
   end

   assign trim_o = trim_reg;
endmodule : ultc_trim_keeper

// ---- hdl/ultc_line_test.sv ----
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
module ultc_line_test
   import ultc_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // avalon-mm slave
   input wire logic [11:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // configuration and resets
   input wire logic eeprom_present_i,
   input wire logic [2:0] cfg_output_current_trim_i,
   input wire logic otp_programmed_i,
   input wire logic [2:0] otp_trim_i,
   input wire logic usb_reset_i,
   input wire logic lite_reset_i,
   input wire logic hs_mode_i,
   // analog front end
   input wire logic fs_diff_receiver_in_i,
   output logic fs_driver_enable_n_o,
   output logic fs_dp_o,
   output logic fs_dp_oe_o,
   output logic fs_dm_o,
   output logic fs_dm_oe_o,
   output logic [1:0] front_end_tx_valid_bus_o,
   output logic [1:0] hs_tx_bits_o,
   output logic hs_tx_serial_o,
   output logic hs_tx_serial_valid_o,
   output logic hs_current_source_on_o,
   output logic [2:0] hs_output_current_trim_o,
   output logic pos_line_pullup_on_o,
   output logic neg_line_pullup_on_o,
   output logic pos_line_pulldown_on_o,
   output logic neg_line_pulldown_on_o,
   output logic hs_driver_active_o
);
   // =====================================================================
   // helpers
   function automatic logic [31:0] ultc_lane_mask(input logic [3:0] be);
      logic [31:0] m;
      m = 32'h00000000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction : ultc_lane_mask

   function automatic logic ultc_hit(input logic [11:0] addr);
      return addr == ULTC_TEST_OFFS;
   endfunction : ultc_hit

   // =====================================================================
   // bus state
   ultc_bus_state_t state_reg, state_next;
   logic [31:0] ctrl_reg, ctrl_next;
   logic [31:0] rdata_reg, rdata_next;
   logic wait_reg, wait_next;
   logic rx_reg;
   logic serial_phase_reg, serial_phase_next;
   logic [1:0] ser_bits_reg, ser_bits_next;
   logic [1:0] ser_valid_reg, ser_valid_next;
   logic ser_out_reg, ser_out_next;
   logic ser_out_valid_reg, ser_out_valid_next;
   logic trim_we;
   logic [2:0] trim_val;
   logic [31:0] wmask;
   logic [31:0] merged;
   logic [31:0] read_word;

   ultc_trim_keeper u_trim (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .eeprom_present_i(eeprom_present_i),
      .cfg_output_current_trim_i(cfg_output_current_trim_i),
      .otp_programmed_i(otp_programmed_i),
      .otp_trim_i(otp_trim_i),
      .usb_reset_i(usb_reset_i),
      .lite_reset_i(lite_reset_i),
      .sw_we_i(trim_we),
      .sw_trim_i(merged[ULTC_TRIM_LSB +: 3]),
      .trim_o(trim_val)
   );

   always_comb begin
      wmask = ultc_lane_mask(avs_byteenable_i) & ULTC_WRITE_MASK;
      merged = (ctrl_reg & ~wmask) | (avs_writedata_i & wmask);
      merged[ULTC_TRIM_LSB +: 3] = avs_byteenable_i[1]
         ? avs_writedata_i[ULTC_TRIM_LSB +: 3] : trim_val;
      read_word = ctrl_reg & ULTC_WRITE_MASK;
      read_word[ULTC_FS_RX_BIT] = rx_reg;
      read_word[ULTC_TRIM_LSB +: 3] = trim_val;
   end

   always_comb begin
      state_next = state_reg;
      ctrl_next = ctrl_reg;
      rdata_next = rdata_reg;
      wait_next = 1'b1;
      trim_we = 1'b0;
      case (state_reg)
         ULTC_IDLE: begin
            // one wait cycle gives a registered answer on every access
            if (avs_read_i || avs_write_i) begin
               state_next = ULTC_ACK;
               wait_next = 1'b0;
               if (avs_write_i && ultc_hit(avs_address_i)) begin
                  ctrl_next = merged;
                  // the illegal mask 10 is stored as given; the front-end
                  // bus suppresses it below
                  trim_we = 1'b1;
               end
               if (avs_read_i) begin
                  rdata_next = ultc_hit(avs_address_i) ? read_word
                                                       : ULTC_UNMAPPED_DATA;
               end
            end
         end
         ULTC_ACK: begin
            state_next = ULTC_IDLE;
         end
         default: begin
            state_next = ULTC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         state_reg <= ULTC_IDLE;
         ctrl_reg <= ULTC_RESET_VAL;
         rdata_reg <= ULTC_RESET_VAL;
         wait_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
         rdata_reg <= rdata_next;
         wait_reg <= wait_next;
      end
   end

   // =====================================================================
   // receiver capture and lsb-first serialiser
   always_comb begin
      serial_phase_next = ~serial_phase_reg;
      ser_bits_next = ser_bits_reg;
      ser_valid_next = ser_valid_reg;
      if (!serial_phase_reg) begin
         ser_bits_next = ctrl_reg[ULTC_TXDATA_LSB +: 2];
         ser_valid_next = ctrl_reg[ULTC_TXVALID_LSB +: 2];
         if (ser_valid_next == ULTC_VALID_ILLEGAL) begin
            ser_valid_next = 2'h0;
         end
         ser_out_next = ser_bits_next[0];
         ser_out_valid_next = ser_valid_next[0];
      end else begin
         ser_out_next = ser_bits_reg[1];
         ser_out_valid_next = ser_valid_reg[1];
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         rx_reg <= 1'b0;
         serial_phase_reg <= 1'b0;
         ser_bits_reg <= 2'h0;
         ser_valid_reg <= 2'h0;
         ser_out_reg <= 1'b0;
         ser_out_valid_reg <= 1'b0;
      end else begin
         rx_reg <= fs_diff_receiver_in_i;
         serial_phase_reg <= serial_phase_next;
         ser_bits_reg <= ser_bits_next;
         ser_valid_reg <= ser_valid_next;
         ser_out_reg <= ser_out_next;
         ser_out_valid_reg <= ser_out_valid_next;
      end
   end

   // =====================================================================
   // analog controls, registered
   logic [20:0] afe_reg, afe_next;
   always_comb begin
      afe_next[0] = ctrl_reg[ULTC_FS_OE_N_BIT];
      afe_next[1] = ctrl_reg[ULTC_FS_POS_BIT];
      afe_next[2] = ~ctrl_reg[ULTC_FS_OE_N_BIT];
      afe_next[3] = ctrl_reg[ULTC_FS_NEG_BIT];
      afe_next[5:4] = (ctrl_reg[ULTC_TXVALID_LSB +: 2] == ULTC_VALID_ILLEGAL)
         ? 2'h0 : ctrl_reg[ULTC_TXVALID_LSB +: 2];
      afe_next[7:6] = ctrl_reg[ULTC_TXDATA_LSB +: 2];
      afe_next[8] = ctrl_reg[ULTC_CS_EN_BIT] | hs_mode_i;
      afe_next[11:9] = trim_val;
      afe_next[15:12] = ctrl_reg[ULTC_TERM_LSB +: 4];
      afe_next[16] = ctrl_reg[ULTC_TXACTIVE_BIT];
      afe_next[20:17] = 4'h0;
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         afe_reg <= 21'h000001;
      end else begin
         afe_reg <= afe_next;
      end
   end

   assign avs_readdata_o = rdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign fs_driver_enable_n_o = afe_reg[0];
   assign fs_dp_o = afe_reg[1];
   assign fs_dp_oe_o = afe_reg[2];
   assign fs_dm_o = afe_reg[3];
   assign fs_dm_oe_o = afe_reg[2];
   assign front_end_tx_valid_bus_o = afe_reg[5:4];
   assign hs_tx_bits_o = afe_reg[7:6];
   assign hs_tx_serial_o = ser_out_reg;
   assign hs_tx_serial_valid_o = ser_out_valid_reg;
   assign hs_current_source_on_o = afe_reg[8];
   assign hs_output_current_trim_o = afe_reg[11:9];
   assign pos_line_pullup_on_o = afe_reg[15];
   assign neg_line_pullup_on_o = afe_reg[14];
   assign pos_line_pulldown_on_o = afe_reg[13];
   assign neg_line_pulldown_on_o = afe_reg[12];
   assign hs_driver_active_o = afe_reg[16];
endmodule : ultc_line_test

// ---- verif/ultc_line_test_props.sv ----
`timescale 1ns/1ps
// =====================================================================
// bus timing and field relations of the line test register
module ultc_line_test_props (
   // clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // bus
   input wire logic [11:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // side inputs
   input wire logic eeprom_present_i,
   input wire logic usb_reset_i,
   input wire logic lite_reset_i,
   input wire logic hs_mode_i,
   // front end
   input wire logic fs_driver_enable_n_o,
   input wire logic fs_dp_o,
   input wire logic fs_dp_oe_o,
   input wire logic fs_dm_oe_o,
   input wire logic [1:0] front_end_tx_valid_bus_o,
   input wire logic hs_current_source_on_o,
   input wire logic [2:0] hs_output_current_trim_o,
   input wire logic pos_line_pullup_on_o,
   input wire logic neg_line_pullup_on_o,
   input wire logic pos_line_pulldown_on_o,
   input wire logic neg_line_pulldown_on_o,
   input wire logic hs_driver_active_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // full-word write completing, no restore competing for the trim
   sequence s_wr;
      avs_write_i && !avs_waitrequest_o && avs_address_i == 12'h0C4 &&
      avs_byteenable_i == 4'hF && !usb_reset_i && !lite_reset_i;
   endsequence
   sequence s_rd(logic mapped);
      avs_read_i && !avs_waitrequest_o &&
      ((avs_address_i == 12'h0C4) == mapped);
   endsequence
   AST_WAIT_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   AST_OE_PAIR: assert property (fs_dp_oe_o == !fs_driver_enable_n_o &&
      fs_dm_oe_o == fs_dp_oe_o) else $error("line enables disagree");
   AST_OE_WRITE: assert property (s_wr |=>
      fs_driver_enable_n_o == $past(avs_writedata_i[22]))
      else $error("driver enable not from write");
   AST_FS_DATA: assert property (s_wr |=>
      fs_dp_o == $past(avs_writedata_i[21])) else $error("dp not from write");
   AST_TXVALID: assert property (front_end_tx_valid_bus_o != 2'h2)
      else $error("illegal valid code on bus");
   AST_CS_HS: assert property ($past(rstn_i) && $past(hs_mode_i) &&
      hs_mode_i |=> hs_current_source_on_o) else $error("source off in hs");
   AST_TRIM_WR: assert property (s_wr |=>
      hs_output_current_trim_o == $past(avs_writedata_i[10:8]))
      else $error("trim not from write");
   AST_TERM: assert property (s_wr |=> {pos_line_pullup_on_o,
      neg_line_pullup_on_o, pos_line_pulldown_on_o, neg_line_pulldown_on_o}
      == $past(avs_writedata_i[7:4])) else $error("terminations wrong");
   AST_ACTIVE: assert property (s_wr |=>
      hs_driver_active_o == $past(avs_writedata_i[1]))
      else $error("driver mode wrong");
   AST_RESTORE: assert property ((usb_reset_i || lite_reset_i) &&
      !eeprom_present_i |-> ##[1:3] hs_output_current_trim_o == 3'h0)
      else $error("trim not restored to zero");
   AST_RSVD_RD: assert property (s_rd(1'b1) |->
      (avs_readdata_o & 32'hFF87000D) == 32'h0) else $error("reserved set");
   AST_UNMAP_RD: assert property (s_rd(1'b0) |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
endmodule : ultc_line_test_props

bind ultc_line_test ultc_line_test_props props_u (.*);

// ---- verif/ultc_line_test_bench.sv ----
`timescale 1ns/1ps
module ultc_line_test_bench
   import ultc_pkg::*;
;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic rd = 1'b0, wr = 1'b0, ee = 1'b0, otpp = 1'b0;
   logic usb = 1'b0, lite = 1'b0, hs = 1'b0, rx = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wd = 32'h00000000;
   logic [31:0] q, rdat;
   logic [3:0] be = 4'h0;
   logic [2:0] cfg = 3'h5, otp = 3'h3;
   logic wt, en_n, dp, dm, ser, serv, cs, act;
   logic [1:0] vbus, txb;
   logic [2:0] trim;
   logic [3:0] term;
   int errors = 0, checks = 0, cyc = 0;
   wire [15:0] outs = {en_n, dp, dm, vbus, txb, cs, trim, term, act};
   ultc_line_test dut_u (.clock_i(clock_i), .rstn_i(rstn_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wt), .eeprom_present_i(ee),
      .cfg_output_current_trim_i(cfg), .otp_programmed_i(otpp),
      .otp_trim_i(otp), .usb_reset_i(usb), .lite_reset_i(lite),
      .hs_mode_i(hs), .fs_diff_receiver_in_i(rx),
      .fs_driver_enable_n_o(en_n), .fs_dp_o(dp), .fs_dp_oe_o(),
      .fs_dm_o(dm), .fs_dm_oe_o(), .front_end_tx_valid_bus_o(vbus),
      .hs_tx_bits_o(txb), .hs_tx_serial_o(ser), .hs_tx_serial_valid_o(serv),
      .hs_current_source_on_o(cs), .hs_output_current_trim_o(trim),
      .pos_line_pullup_on_o(term[3]), .neg_line_pullup_on_o(term[2]),
      .pos_line_pulldown_on_o(term[1]), .neg_line_pulldown_on_o(term[0]),
      .hs_driver_active_o(act));
   // =====================================================================
   // clock, timeout and helpers
   initial begin
      forever #25 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         stop_test();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // waitrequest is sampled before this edge's updates land
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] b);
      @(posedge clock_i);
      adr <= a;
      wd <= d;
      be <= b;
      wr <= w;
      rd <= !w;
      do @(posedge clock_i); while (wt !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task automatic wreg(input logic [31:0] d, input logic [3:0] b = 4'hF,
      input logic [11:0] a = ULTC_TEST_OFFS);
      bus(1'b1, a, d, b);
      @(negedge clock_i);
   endtask : wreg
   task automatic rchk(input logic [31:0] e, input logic [11:0] a = ULTC_TEST_OFFS);
      bus(1'b0, a, 32'h0, 4'hF);
      chk("readdata", e, q);
   endtask : rchk
   // =====================================================================
   // scenarios
   task automatic power(input logic e, input logic p);
      logic [2:0] t;
      t = e ? cfg : (p ? otp : 3'h0);
      @(posedge clock_i);
      rstn_i <= 1'b0;
      ee <= e;
      otpp <= p;
      repeat (3) @(posedge clock_i);
      rstn_i <= 1'b1;
      // trim loads one edge after release and reaches the pins one later
      repeat (3) @(negedge clock_i);
      chk("outs", {8'h0, t, 5'h0}, outs);
      rchk({21'h0, t, 8'h00});
      for (int k = 0; k < 2; k++) begin
         wreg(32'h00000600, 4'h2);
         chk("trim", 3'h6, trim);
         @(posedge clock_i);
         usb <= (k == 0);
         lite <= (k == 1);
         @(posedge clock_i);
         usb <= 1'b0;
         lite <= 1'b0;
         repeat (3) @(negedge clock_i);
         chk("trim", e ? cfg : 3'h0, trim);
      end
   endtask : power
   task automatic t_regs();
      wreg(32'hFFFFFFFF);
      chk("outs", 16'hFFFF, outs);
      rchk(32'h0070FFF2);
      wreg(32'h000000F0, 4'h1);
      chk("outs", 16'hFFFE, outs);
      wreg(32'hFF87000D);
      chk("outs", 16'h0000, outs);
      rchk(32'h00000000);
      wreg(32'hFFFFFFFF, 4'hF, 12'h0C8);
      rchk(32'h00000000, 12'h0C8);
      chk("outs", 16'h0000, outs);
   endtask : t_regs
   task automatic t_fs();
      wreg(32'h00200000);
      chk("outs", 16'h4000, outs);
      wreg(32'h00500000);
      chk("outs", 16'hA000, outs);
      @(posedge clock_i);
      rx <= 1'b1;
      rchk(32'h00580000);
      @(posedge clock_i);
      rx <= 1'b0;
      rchk(32'h00500000);
   endtask : t_fs
   task automatic t_valid();
      int n;
      for (int v = 0; v < 4; v++) begin
         wreg({16'h0, 2'(v), 2'b01, 12'h0});
         chk("valid_bus", (v == 2) ? 0 : v, vbus);
         rchk({16'h0, 2'(v), 2'b01, 12'h0});
         if (v == 1) begin
            n = 0;
            repeat (4) begin
               @(negedge clock_i);
               if (serv === 1'b1) begin
                  n++;
                  chk("serial", 1, ser);
               end
            end
            chk("slots", 2, n);
         end
      end
   endtask : t_valid
   task automatic t_cs();
      wreg(32'h00000000);
      @(posedge clock_i);
      hs <= 1'b1;
      repeat (3) @(negedge clock_i);
      chk("source", 1, cs);
      @(posedge clock_i);
      hs <= 1'b0;
      repeat (3) @(negedge clock_i);
      chk("source", 0, cs);
   endtask : t_cs
   task automatic stop_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test
   initial begin
      power(1'b0, 1'b0);
      power(1'b0, 1'b1);
      power(1'b1, 1'b1);
      t_regs();
      t_fs();
      t_valid();
      t_cs();
      stop_test();
   end
endmodule : ultc_line_test_bench
